// File: hdl/pcm_pkg.sv
// package: constants and carrier types for the counter mode logic
package pcm_pkg;

    localparam int CNT_W = 16;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] BIN_WRAP = 16'hFFFF;
    localparam logic [15:0] BCD_WRAP = 16'h9999;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_TWO = 16'h0002;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic OUT_RESET = 1'b1;

    typedef enum logic [2:0] {
        PCM_MODE0 = 3'h0,
        PCM_MODE1 = 3'h1,
        PCM_MODE2 = 3'h2,
        PCM_MODE3 = 3'h3,
        PCM_MODE4 = 3'h4,
        PCM_MODE5 = 3'h5
    } pcm_mode_type;

    // host side write strobes for one channel
    typedef struct packed {
        logic ctrl_wr;          // control word written
        pcm_mode_type mode;     // mode carried by the control word
        logic bcd;              // decimal counting format
        logic low_wr;           // low byte latch written
        logic high_wr;          // high byte latch written
        logic [7:0] data;       // byte written
    } pcm_host_wr_type;

    // state shown back to the host
    typedef struct packed {
        logic [15:0] count;     // counting element
        logic null_count;       // latches not yet transferred
        logic out;              // output level
    } pcm_status_type;

endpackage

// File: hdl/pcm_counter.sv
// one 16-bit down-counter channel with its six operating modes
`timescale 1ns/10ps
module pcm_counter
    import pcm_pkg::*;
(
    input wire logic clk,                     // system clock
    input wire logic rst,                     // synchronous reset, high
    input wire pcm_host_wr_type host_wr,      // host write strobes
    input wire logic timer_clock_input,       // timer clock, sampled
    input wire logic channel_two_gate,        // gate, sampled
    output logic channel_two_output,          // counter output
    output pcm_status_type status             // count and state view
);

    logic tclk_reg;
    logic gate_reg;
    logic tclk_rise;
    logic tclk_fall;
    logic gate_rise;
    pcm_mode_type mode_reg;
    logic bcd_reg;
    logic [7:0] count_input_low_latch;
    logic [7:0] count_input_high_latch;
    logic [15:0] ce_reg;
    logic [15:0] ce_next;
    logic out_reg;
    logic null_reg;
    logic load_pend_reg;      // count written, waiting for a pulse
    logic armed_reg;          // mode 1/5 initialized, trigger may start
    logic running_reg;        // element holds a loaded value
    logic trig_flag_reg;      // gate edge flag
    logic trig_seen_reg;      // edge flag captured at rising edge
    logic gate_level_reg;     // gate level captured at rising edge
    logic half_reg;           // mode 3 first half of the period
    logic decr_en;
    logic do_load;
    logic periodic;
    logic [15:0] latched;
    logic [15:0] step;
    logic at_zero;
    logic at_one;
    logic at_two;
    logic at_three;
    logic period_end;         // current periodic cycle is over
    logic out_next;
    logic half_next;

    assign periodic = (mode_reg == PCM_MODE2) || (mode_reg == PCM_MODE3);
    assign latched = {count_input_high_latch, count_input_low_latch};

    // edges of the sampled timer clock and gate
    always_ff @(posedge clk) begin
        if (rst) begin
            tclk_reg <= 1'b0;
            gate_reg <= 1'b0;
        end else begin
            tclk_reg <= timer_clock_input;
            gate_reg <= channel_two_gate;
        end
    end
    assign tclk_rise = timer_clock_input && !tclk_reg;
    assign tclk_fall = !timer_clock_input && tclk_reg;
    assign gate_rise = channel_two_gate && !gate_reg;

    // control word and input latches
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= PCM_MODE0;
            bcd_reg <= 1'b0;
            count_input_low_latch <= 8'h00;
            count_input_high_latch <= 8'h00;
        end else begin
            if (host_wr.ctrl_wr) begin
                mode_reg <= host_wr.mode;
                bcd_reg <= host_wr.bcd;
            end
            if (host_wr.low_wr) begin
                count_input_low_latch <= host_wr.data;
            end
            if (host_wr.high_wr) begin
                count_input_high_latch <= host_wr.data;
            end
        end
    end

    // gate edge flag: set on edge, cleared right after the rising-edge sample
    always_ff @(posedge clk) begin
        if (rst) begin
            trig_flag_reg <= 1'b0;
        end else if (tclk_rise) begin
            trig_flag_reg <= 1'b0;
        end else if (gate_rise) begin
            trig_flag_reg <= 1'b1;
        end
    end

    // an edge in the same cycle as the sample is not lost
    always_ff @(posedge clk) begin
        if (rst) begin
            trig_seen_reg <= 1'b0;
        end else if (tclk_rise) begin
            trig_seen_reg <= trig_flag_reg || gate_rise;
        end else if (tclk_fall) begin
            trig_seen_reg <= 1'b0;
        end
    end

    // gate level for counting, taken at the timer clock rise
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_level_reg <= 1'b0;
        end else if (tclk_rise) begin
            gate_level_reg <= channel_two_gate;
        end
    end

    // a pending count is consumed at the next pulse in modes 0 and 4;
    // periodic modes load at a trigger, at the period end or while not running; hardware modes wait for a trigger
    always_ff @(posedge clk) begin
        if (rst) begin
            load_pend_reg <= 1'b0;
            armed_reg <= 1'b0;
            null_reg <= 1'b0;
        end else begin
            if (host_wr.ctrl_wr) begin
                load_pend_reg <= 1'b0;
                armed_reg <= 1'b0;
                null_reg <= 1'b1;
            end else if (host_wr.high_wr || host_wr.low_wr) begin
                // either byte write marks the latches pending; no wait for the high byte
                load_pend_reg <= 1'b1;
                armed_reg <= 1'b1;
                null_reg <= 1'b1;
            end else if (do_load) begin
                load_pend_reg <= 1'b0;
                null_reg <= 1'b0;
            end
        end
    end

    // decrement by one, binary or decimal, wrapping at zero
    function automatic logic [15:0] pcm_dec(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        r = v;
        if (v == CNT_ZERO) begin
            r = bcd ? BCD_WRAP : BIN_WRAP;
        end else if (!bcd) begin
            r = v - CNT_ONE;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (r[i*4 +: 4] != 4'h0) begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    break;
                end
                r[i*4 +: 4] = 4'h9;
            end
        end
        return r;
    endfunction

    // terminal values of the counting element
    assign at_zero = (ce_reg == CNT_ZERO);
    assign at_one = (ce_reg == CNT_ONE);
    assign at_two = (ce_reg == CNT_TWO);
    assign at_three = (ce_reg == (CNT_TWO | CNT_ONE));

    // mode 3 counts by two; an odd count spends its extra pulse in the high half
    // limitation: decimal steps by two rely on the low digit parity only
    always_comb begin
        step = pcm_dec(ce_reg, bcd_reg);
        if (mode_reg == PCM_MODE3) begin
            if (ce_reg[0] && !at_one) begin
                if (!half_reg) begin
                    // low half of an odd count is one pulse shorter
                    step = pcm_dec(pcm_dec(step, bcd_reg), bcd_reg);
                end
            end else begin
                step = pcm_dec(step, bcd_reg);
            end
        end
    end

    // end of the current counting cycle in the periodic modes
    always_comb begin
        if (mode_reg == PCM_MODE2) begin
            period_end = at_one;
        end else begin
            period_end = at_two || at_zero || (at_three && !half_reg);
        end
    end

    // load decision taken on the falling edge
    always_comb begin
        do_load = 1'b0;
        decr_en = 1'b0;
        if (tclk_fall) begin
            unique case (mode_reg)
                PCM_MODE0, PCM_MODE4: begin
                    do_load = load_pend_reg;
                    decr_en = !load_pend_reg && running_reg && gate_level_reg;
                end
                PCM_MODE1, PCM_MODE5: begin
                    do_load = armed_reg && trig_seen_reg;
                    decr_en = running_reg && !do_load &&
                        (mode_reg == PCM_MODE1 || gate_level_reg);
                end
                PCM_MODE2, PCM_MODE3: begin
                    // a trigger or a stopped element takes a new count at once, else the period end
                    do_load = armed_reg &&
                        (trig_seen_reg || !running_reg || period_end);
                    decr_en = running_reg && gate_level_reg && !do_load;
                end
                default: begin
                    do_load = 1'b0;
                    decr_en = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        ce_next = ce_reg;
        if (do_load) begin
            ce_next = latched;
        end else if (decr_en) begin
            ce_next = step;
        end
    end

    // counting element updated only on timer clock falling edges
    always_ff @(posedge clk) begin
        if (rst) begin
            ce_reg <= CNT_RESET;
            running_reg <= 1'b0;
        end else begin
            if (host_wr.ctrl_wr) begin
                running_reg <= 1'b0;
            end else if (tclk_fall) begin
                ce_reg <= ce_next;
                if (do_load) begin
                    running_reg <= 1'b1;
                end
            end
        end
    end

    // next output level per mode, applied only at a timer clock fall
    always_comb begin
        out_next = out_reg;
        half_next = half_reg;
        unique case (mode_reg)
            PCM_MODE0: begin
                if (decr_en && at_one) begin
                    out_next = 1'b1;
                end
            end
            PCM_MODE1: begin
                if (do_load) begin
                    out_next = 1'b0;
                end else if (decr_en && at_one) begin
                    out_next = 1'b1;
                end
            end
            PCM_MODE2: begin
                out_next = !(decr_en && at_two);
            end
            PCM_MODE3: begin
                if (do_load && running_reg && !trig_seen_reg) begin
                    // each reload ends one half of the square wave
                    half_next = !half_reg;
                    out_next = !half_reg;
                end else if (do_load) begin
                    half_next = 1'b1;
                    out_next = 1'b1;
                end
            end
            PCM_MODE4, PCM_MODE5: begin
                out_next = !(decr_en && at_one);
            end
            default: begin
                out_next = 1'b1;
            end
        endcase
    end

    // output level: control words, mode 0 count writes and a low gate in modes 2 and 3 act at once
    always_ff @(posedge clk) begin
        if (rst) begin
            out_reg <= OUT_RESET;
            half_reg <= 1'b1;
        end else if (host_wr.ctrl_wr) begin
            out_reg <= (host_wr.mode != PCM_MODE0);
            half_reg <= 1'b1;
        end else if (mode_reg == PCM_MODE0 && (host_wr.low_wr || host_wr.high_wr)) begin
            out_reg <= 1'b0;
        end else if (periodic && !channel_two_gate) begin
            out_reg <= 1'b1;
            half_reg <= 1'b1;
        end else if (tclk_fall) begin
            out_reg <= out_next;
            half_reg <= half_next;
        end
    end

    assign channel_two_output = out_reg;
    assign status = '{count: ce_reg, null_count: null_reg, out: out_reg};

endmodule

// File: bench/pcm_timer_model.sv
// partner model: free-running timer clock seen by the channel
`timescale 1ns/10ps
module pcm_timer_model #(
    parameter int HALF = 4
) (
    input wire logic clk,            // system clock
    output logic timer_clock_input   // timer clock to the channel
);
    int div_cnt = 0;
    initial timer_clock_input = 1'b0;
    // each pulse is a full high phase then a full low phase
    always @(posedge clk) begin
        #1;
        if (div_cnt == HALF - 1) begin
            div_cnt = 0;
            timer_clock_input = ~timer_clock_input;
        end else begin
            div_cnt = div_cnt + 1;
        end
    end
endmodule

// File: bench/pcm_counter_sva.sv
// checker: port properties of the counter channel
`timescale 1ns/10ps
module pcm_counter_sva
    import pcm_pkg::*;
(
    input wire logic clk,                 // system clock
    input wire logic rst,                 // reset
    input wire pcm_host_wr_type host_wr,  // host writes
    input wire logic timer_clock_input,   // timer clock
    input wire logic channel_two_gate,    // gate
    input wire logic channel_two_output,  // output
    input wire pcm_status_type status     // status
);
    pcm_mode_type mode_reg;
    logic tc_reg;
    logic [3:0] since_fall_reg;
    logic wr_any;
    assign wr_any = host_wr.ctrl_wr | host_wr.low_wr | host_wr.high_wr;
    always_ff @(posedge clk) begin
        if (rst) mode_reg <= PCM_MODE0;
        else if (host_wr.ctrl_wr) mode_reg <= host_wr.mode;
    end
    always_ff @(posedge clk) begin
        tc_reg <= timer_clock_input;
        if (rst) since_fall_reg <= 4'hF;
        else if (tc_reg && !timer_clock_input) since_fall_reg <= 4'h0;
        else if (since_fall_reg != 4'hF) since_fall_reg <= since_fall_reg + 4'h1;
    end
    a_reset_out_high: assert property (@(posedge clk)
        rst |=> channel_two_output && status.count == 16'h0000)
        else $error("output or count not reset");
    a_count_by_timer: assert property (@(posedge clk) disable iff (rst)
        $changed(status.count) && !$past(rst) |-> since_fall_reg <= 4'h3)
        else $error("count moved without a timer fall");
    a_mode0_ctrl_low: assert property (@(posedge clk) disable iff (rst)
        host_wr.ctrl_wr && host_wr.mode == PCM_MODE0 |=> !channel_two_output)
        else $error("mode 0 control word left output high");
    a_ctrl_out_high: assert property (@(posedge clk) disable iff (rst)
        host_wr.ctrl_wr && host_wr.mode != PCM_MODE0 |=> channel_two_output)
        else $error("control word left output low");
    a_gate_forces_high: assert property (@(posedge clk) disable iff (rst)
        (mode_reg inside {PCM_MODE2, PCM_MODE3} && !channel_two_gate && !wr_any)[*4]
        |-> channel_two_output)
        else $error("low gate did not force output high");
    a_mode0_gate_hold: assert property (@(posedge clk) disable iff (rst)
        (mode_reg == PCM_MODE0 && !channel_two_gate && !wr_any)[*8]
        |-> $stable(channel_two_output))
        else $error("output moved while gated off");
    a_strobe_one_cycle: assert property (@(posedge clk) disable iff (rst)
        $fell(channel_two_output) && mode_reg inside {PCM_MODE4, PCM_MODE5}
        |-> (!channel_two_output)[*6] ##[1:4] channel_two_output)
        else $error("strobe not one timer cycle long");
    a_zero_out_high: assert property (@(posedge clk) disable iff (rst)
        mode_reg == PCM_MODE0 && $changed(status.count) && !$past(rst)
        && status.count == 16'h0000 |-> channel_two_output)
        else $error("output low at terminal count");
    a_null_on_write: assert property (@(posedge clk) disable iff (rst)
        host_wr.low_wr || host_wr.high_wr |=> status.null_count)
        else $error("count write did not mark latches pending");
endmodule
bind pcm_counter pcm_counter_sva pcm_counter_sva_inst (.clk(clk), .rst(rst),
    .host_wr(host_wr), .timer_clock_input(timer_clock_input),
    .channel_two_gate(channel_two_gate), .channel_two_output(channel_two_output),
    .status(status));

// File: bench/testbench.sv
// testbench: mode-by-mode scenarios for the counter channel
`timescale 1ns/10ps
module testbench
    import pcm_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pcm_host_wr_type host_wr = '0;
    logic timer_clock_input;
    logic channel_two_gate = 1'b0;
    logic channel_two_output;
    pcm_status_type status;
    int fails = 0;
    int total_checks = 0;
    int falls = 0;
    int cycles = 0;
    int n;
    always #5 clk = ~clk;
    always @(negedge timer_clock_input) falls++;
    pcm_timer_model pcm_timer_model_inst (.clk(clk), .timer_clock_input(timer_clock_input));
    pcm_counter pcm_counter_inst (.clk(clk), .rst(rst), .host_wr(host_wr),
        .timer_clock_input(timer_clock_input), .channel_two_gate(channel_two_gate),
        .channel_two_output(channel_two_output), .status(status));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            complete_run();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input pcm_host_wr_type w);
        @(posedge clk);
        #1 host_wr = w;
        @(posedge clk);
        #1 host_wr = '0;
    endtask
    // high byte lands just after a timer fall so a whole pulse follows it
    task automatic load(input logic [15:0] c);
        wr('{1'b0, PCM_MODE0, 1'b0, 1'b1, 1'b0, c[7:0]});
        @(negedge timer_clock_input);
        wr('{1'b0, PCM_MODE0, 1'b0, 1'b0, 1'b1, c[15:8]});
    endtask
    task automatic setup(input pcm_mode_type m, input logic [15:0] c);
        wr('{1'b1, m, 1'b0, 1'b0, 1'b0, 8'h00});
        load(c);
    endtask
    task automatic wait_out(input logic lvl, output int k);
        int b = falls;
        int t = 0;
        while (channel_two_output !== lvl && t < 400) begin
            @(posedge clk);
            #1 t++;
        end
        if (t >= 400) fails++;
        k = falls - b;
    endtask
    task automatic trigger();
        @(negedge timer_clock_input);
        @(posedge clk);
        #1 channel_two_gate = 1'b1;
    endtask
    task automatic test_mode0();
        channel_two_gate = 1'b1;
        setup(PCM_MODE0, 16'h0003);
        check(16'(channel_two_output), 16'h0000);
        wait_out(1'b1, n);
        check(16'(n), 16'h0004);
        load(16'h0002);
        wait_out(1'b1, n);
        check(16'(n), 16'h0003);
        #1 channel_two_gate = 1'b0;
        load(16'h0003);
        repeat (5) @(negedge timer_clock_input);
        check(16'(channel_two_output), 16'h0000);
        check(status.count, 16'h0003);
        check(16'(status.null_count), 16'h0000);
        trigger();
        wait_out(1'b1, n);
        check(16'(n), 16'h0003);
        wr('{1'b1, PCM_MODE0, 1'b1, 1'b0, 1'b0, 8'h00});
        load(16'h0010);
        wait_out(1'b1, n);
        check(16'(n), 16'h000B);
        @(negedge timer_clock_input);
        @(posedge clk);
        #1 check(status.count, 16'h9999);
        $display("mode 0 test done");
    endtask
    task automatic test_one_shots();
        channel_two_gate = 1'b0;
        setup(PCM_MODE1, 16'h0003);
        check(16'(channel_two_output), 16'h0001);
        trigger();
        wait_out(1'b0, n);
        check(16'(n), 16'h0001);
        wait_out(1'b1, n);
        check(16'(n), 16'h0003);
        #1 channel_two_gate = 1'b0;
        setup(PCM_MODE5, 16'h0003);
        repeat (6) @(negedge timer_clock_input);
        check(16'(channel_two_output), 16'h0001);
        trigger();
        wait_out(1'b0, n);
        check(16'(n), 16'h0004);
        wait_out(1'b1, n);
        check(16'(n), 16'h0001);
        channel_two_gate = 1'b1;
        setup(PCM_MODE4, 16'h0003);
        wait_out(1'b0, n);
        check(16'(n), 16'h0004);
        wait_out(1'b1, n);
        check(16'(n), 16'h0001);
        $display("one-shot and strobe test done");
    endtask
    task automatic test_periodic();
        channel_two_gate = 1'b1;
        setup(PCM_MODE2, 16'h0004);
        wait_out(1'b0, n);
        wait_out(1'b1, n);
        check(16'(n), 16'h0001);
        wait_out(1'b0, n);
        check(16'(n), 16'h0003);
        #1 channel_two_gate = 1'b0;
        repeat (4) @(posedge clk);
        check(16'(channel_two_output), 16'h0001);
        #1 channel_two_gate = 1'b1;
        for (int c = 4; c < 6; c++) begin
            setup(PCM_MODE3, 16'(c));
            wait_out(1'b0, n);
            wait_out(1'b1, n);
            check(16'(n), 16'(c / 2));
            wait_out(1'b0, n);
            check(16'(n), 16'((c + 1) / 2));
        end
        $display("periodic test done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        test_mode0();
        test_one_shots();
        test_periodic();
        complete_run();
    end
endmodule
